/* dv/sfspi_front_end_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module sfspi_fe_asserts (
  input wire logic                       clk_sys_in,
  input wire logic                       reset_in,
  input wire logic                       cs_n_in,
  input wire logic                       sck_in,
  input wire logic [sfspi_pkg::IO_W-1:0] io_out,
  input wire logic [sfspi_pkg::IO_W-1:0] io_oe_out,
  input wire logic                       busy_in,
  input wire logic                       quad_pins_enable_in,
  input wire logic                       wp_n_out,
  input wire sfspi_pkg::sfspi_power_e    power_state_out,
  input wire logic                       selected_out,
  input wire logic                       held_out,
  input wire logic                       tx_enable_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Select seen high long enough to pass the pin synchroniser
  sequence desel_s; cs_n_in [*6]; endsequence
  sequence idle_s; (cs_n_in && !busy_in) [*6]; endsequence
  oe_released_a: assert property (desel_s |-> io_oe_out == 4'h0)
    else $error("data lines driven while deselected");
  standby_power_a: assert property (idle_s |->
    power_state_out == sfspi_pkg::SFSPI_PWR_STANDBY)
    else $error("no standby while deselected and idle");
  active_power_a: assert property ($rose(selected_out) |=>
    power_state_out == sfspi_pkg::SFSPI_PWR_ACTIVE)
    else $error("no active power after select");
  select_edge_a: assert property ($rose(selected_out) |->
    $past(cs_n_in, 6) && !$past(cs_n_in, 2))
    else $error("frame began without a select fall");
  no_read_drive_a: assert property (!tx_enable_in |->
    io_oe_out == 4'h0)
    else $error("lines driven outside a read");
  out_line_on_a: assert property (selected_out && tx_enable_in |->
    io_oe_out[1])
    else $error("serial out not driven during read");
  out_on_fall_a: assert property ($changed(io_out) |->
    !sck_in && !$past(sck_in, 2))
    else $error("output changed away from a clock fall");
  hold_clk_low_a: assert property ($rose(held_out) |->
    !$past(sck_in, 3))
    else $error("pause began with clock high");
  desel_clears_a: assert property (desel_s |->
    !held_out && !selected_out)
    else $error("pause or frame kept after deselect");
  quad_wp_a: assert property (quad_pins_enable_in [*2] |->
    wp_n_out)
    else $error("protect active with quad pins enabled");
endmodule : sfspi_fe_asserts
bind sfspi_front_end sfspi_fe_asserts u_chk (.clk_sys_in, .reset_in,
  .cs_n_in, .sck_in, .io_out, .io_oe_out, .busy_in,
  .quad_pins_enable_in, .wp_n_out, .power_state_out, .selected_out,
  .held_out, .tx_enable_in);
`default_nettype wire

/* dv/sfspi_front_end_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sfspi_front_end_tb_top;
  typedef struct packed {
    logic        m3;
    logic [7:0]  c;
    logic [23:0] a;
    logic [7:0]  d;
  } sfspi_row_s;
  localparam sfspi_row_s ROWS [3] = '{
    '{1'b0, 8'h02, 24'h123456, 8'h81},
    '{1'b1, 8'h02, 24'hffffff, 8'h7e},
    '{1'b0, 8'h32, 24'h000100, 8'h00}};
  logic clk_sys_in = 1'b0;
  logic rst = 1'b1, busy = 1'b0, qpe = 1'b0, rx_ready = 1'b1;
  logic tx_en = 1'b0, flip = 1'b0;
  sfspi_pkg::sfspi_width_e tx_width = sfspi_pkg::SFSPI_WIDTH_SINGLE;
  logic [7:0] tx_data = 8'h00, rx;
  logic cs_n, sck, si, hold_n, wp_n, wp_o, sel, held, rx_valid, drop;
  logic [3:0] io_in, io_out, io_oe;
  sfspi_pkg::sfspi_power_e power;
  sfspi_pkg::sfspi_rx_byte_s rx_byte, q[$];
  sfspi_pkg::sfspi_addr_s addr;
  sfspi_pkg::sfspi_kind_e k;
  logic [39:0] v;
  int n_errors = 0, checks_done = 0;
  int loads = 0, l0;
  logic tx_valid = 1'b1, addr_ok, tx_rdy, undr;
  always @(posedge clk_sys_in) if (tx_rdy) loads++;
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) flip <= ~flip;
  always @(posedge clk_sys_in) if (rx_valid && rx_ready) q.push_back(rx_byte);
  // Undriven serial out shows a changing level, protect and hold follow the host's wp_n and hold_n
  assign io_in = (io_oe & io_out) | (~io_oe & {hold_n, wp_n, flip, si});
  sfspi_host_model host (.cs_n_out(cs_n), .sck_out(sck), .si_out(si),
    .hold_n_out(hold_n), .wp_n_out(wp_n), .pins_in(io_in));
  sfspi_front_end DUT (.clk_sys_in(clk_sys_in), .reset_in(rst),
    .cs_n_in(cs_n), .sck_in(sck), .io_in(io_in), .io_out(io_out),
    .io_oe_out(io_oe), .busy_in(busy), .quad_pins_enable_in(qpe),
    .wp_n_out(wp_o), .power_state_out(power), .selected_out(sel),
    .held_out(held), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .rx_byte_out(rx_byte), .rx_dropped_out(drop), .addr_out(addr),
    .addr_valid_out(addr_ok), .tx_enable_in(tx_en), .tx_width_in(tx_width),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_rdy), .tx_data_in(tx_data),
    .tx_underrun_out(undr));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic wait_q(input int n);
    int t;
    t = 0;
    while (q.size() < n && t < 500) begin
      @(negedge clk_sys_in);
      t++;
    end
    if (q.size() < n) begin
      n_errors++;
      stop_test();
    end
  endtask : wait_q
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst = 1'b0;
    @(negedge clk_sys_in);
    chk("power", power, sfspi_pkg::SFSPI_PWR_STANDBY);
    chk("oe", io_oe, 4'h0);
    chk("wp", wp_o, 1'b1);
    host.xfer(8'ha5, 1, rx);
    chk("sel", sel, 1'b0);
    host.close_frame();
    host.xfer(8'h5a, 1, rx);
    chk("ignored", q.size(), 0);
    @(negedge clk_sys_in);
    busy = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    chk("busy", power, sfspi_pkg::SFSPI_PWR_BUSY);
    busy = 1'b0;
    foreach (ROWS[r]) begin
      q.delete();
      v = {ROWS[r].c, ROWS[r].a, ROWS[r].d};
      host.open_frame(ROWS[r].m3);
      chk("active", power, sfspi_pkg::SFSPI_PWR_ACTIVE);
      for (int b = 0; b < 5; b++) host.xfer(v[39-8*b -: 8], 1, rx);
      chk("addr", addr, ROWS[r].a);
      chk("addr ok", addr_ok, 1'b1);
      host.close_frame();
      wait_q(5);
      for (int b = 0; b < 5; b++) begin
        k = (b == 0) ? sfspi_pkg::SFSPI_KIND_CMD :
            (b < 4) ? sfspi_pkg::SFSPI_KIND_ADDR : sfspi_pkg::SFSPI_KIND_DATA;
        chk("rx", q[b], {k, v[39-8*b -: 8]});
      end
    end
    for (int w = 0; w < 3; w++) begin
      @(negedge clk_sys_in);
      qpe = (w == 2);
      tx_width = sfspi_pkg::sfspi_width_e'(w);
      tx_data = 8'hc6 + 8'(w);
      host.open_frame(1'b0);
      host.xfer(8'h0b, 1, rx);
      @(negedge clk_sys_in);
      tx_en = 1'b1;
      l0 = loads;
      host.xfer(8'h00, 1 << w, rx);
      chk("read", rx, 8'hc6 + 8'(w));
      chk("loads", loads - l0, 1);
      chk("oe", io_oe, (w == 0) ? 4'h2 : (w == 1) ? 4'h3 : 4'hf);
      host.close_frame();
      chk("oe off", io_oe, 4'h0);
      @(negedge clk_sys_in);
      tx_en = 1'b0;
    end
    // Read with no byte offered: zeros go out and the flag sticks
    qpe = 1'b0;
    tx_valid = 1'b0;
    tx_width = sfspi_pkg::SFSPI_WIDTH_SINGLE;
    host.open_frame(1'b0);
    host.xfer(8'h0b, 1, rx);
    @(negedge clk_sys_in);
    tx_en = 1'b1;
    host.xfer(8'h00, 1, rx);
    chk("zeros", rx, 8'h00);
    chk("underrun", undr, 1'b1);
    host.close_frame();
    @(negedge clk_sys_in);
    tx_en = 1'b0;
    tx_valid = 1'b1;
    q.delete();
    host.open_frame(1'b0);
    chk("underrun clr", undr, 1'b0);
    host.xfer(8'h9f, 1, rx);
    host.pause(1'b1);
    chk("held", held, 1'b1);
    host.xfer(8'h11, 1, rx);
    host.pause(1'b0);
    chk("held", held, 1'b0);
    host.xfer(8'h22, 1, rx);
    host.pause(1'b1);
    host.close_frame();
    chk("held", held, 1'b0);
    wait_q(2);
    chk("after hold", q[1], {sfspi_pkg::SFSPI_KIND_ADDR, 8'h22});
    host.wp_n_out = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    chk("wp", wp_o, 1'b0);
    q.delete();
    rx_ready = 1'b0;
    host.open_frame(1'b0);
    for (int b = 0; b < 18; b++) host.xfer(8'(b), 1, rx);
    host.close_frame();
    chk("full", drop, 1'b1);
    @(negedge clk_sys_in);
    rx_ready = 1'b1;
    wait_q(16);
    repeat (8) @(negedge clk_sys_in);
    chk("drained", q.size(), 16);
    chk("last", q[15], {sfspi_pkg::SFSPI_KIND_DATA, 8'h0f});
    q.delete();
    host.open_frame(1'b0);
    for (int b = 0; b < 261; b++) begin
      host.xfer(8'(b), 1, rx);
      if (b == 259) chk("limit", drop, 1'b0);
    end
    chk("over", drop, 1'b1);
    host.close_frame();
    wait_q(260);
    chk("count", q.size(), 260);
    // Second reset with select falling inside it: no frame may follow
    @(negedge clk_sys_in);
    rst = 1'b1;
    host.open_frame(1'b0);
    @(negedge clk_sys_in);
    rst = 1'b0;
    @(negedge clk_sys_in);
    chk("reset drop", drop, 1'b0);
    q.delete();
    host.xfer(8'h06, 1, rx);
    chk("reset sel", sel, 1'b0);
    repeat (4) @(negedge clk_sys_in);
    chk("reset rx", q.size(), 0);
    stop_test();
  end
endmodule : sfspi_front_end_tb_top
`default_nettype wire

/* dv/sfspi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sfspi_host_model (
  output logic            cs_n_out,
  output logic            sck_out,
  output logic            si_out,
  output logic            hold_n_out,
  output logic            wp_n_out,
  input  wire logic [3:0] pins_in
);
  localparam realtime HALF = 62.5;
  logic idle_hi;
  // Select starts low at power-up so a frame needs a later fall
  initial begin
    cs_n_out = 1'b0;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out = 1'b1;
    idle_hi = 1'b0;
  end
  task automatic open_frame(input logic mode3);
    idle_hi = mode3;
    sck_out = mode3;
    #(HALF);
    cs_n_out = 1'b0;
    #(HALF);
  endtask : open_frame
  // Drive on the fall, sample on the rise, most significant bit first
  task automatic xfer(input logic [7:0] tx, input int step,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i -= step) begin
      sck_out = 1'b0;
      si_out = tx[i];
      #(HALF);
      sck_out = 1'b1;
      if (step == 1) rx = {rx[6:0], pins_in[1]};
      else if (step == 2) rx = {rx[5:0], pins_in[1:0]};
      else rx = {rx[3:0], pins_in};
      #(HALF);
    end
  endtask : xfer
  task automatic pause(input logic on);
    sck_out = 1'b0;
    #(HALF);
    hold_n_out = !on;
    #(HALF);
  endtask : pause
  task automatic close_frame();
    sck_out = idle_hi;
    #(HALF);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #(HALF * 4);
  endtask : close_frame
endmodule : sfspi_host_model
`default_nettype wire

/* logic/sfspi_front_end.sv */
// Overview of operation
// - Chip select high: all data outputs released
// - Deselected and idle: standby power mode
// - Chip select low: active mode, ready
// - Ignore traffic until a chip select fall
// - Sample input bits on clock rising edges
// - Update output bits on clock falling edges
// - Single-bit input arrives only on line zero
// - Dual/quad reads: line zero becomes output
// - Ignore input line while deselected
// - Line one driven only when selected, returning
// - Dual read: line one plus zero, two bits
// - Clock idling low or high both work
// - At most 256 data bytes per program
// - Address splits into page and byte
// - Hold enters and leaves only with clock low
// - Deselect during hold resets interface logic
// - Quad pins enable turns protect into data
`timescale 1ns/10ps
`default_nettype none

module sfspi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W:0]   wr_ptr_reg;
  logic [PTR_W:0]   rd_ptr_reg;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full  = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                 (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push  = in_valid_in & ~full;
  assign pop   = out_ready_in & ~empty;

  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem_reg[rd_ptr_reg[PTR_W-1:0]];

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule : sfspi_fifo

module sfspi_front_end (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_in,
  input  wire logic                       cs_n_in,
  input  wire logic                       sck_in,
  input  wire logic [sfspi_pkg::IO_W-1:0] io_in,
  output logic      [sfspi_pkg::IO_W-1:0] io_out,
  output logic      [sfspi_pkg::IO_W-1:0] io_oe_out,
  input  wire logic                       busy_in,
  input  wire logic                       quad_pins_enable_in,
  output logic                            wp_n_out,
  output sfspi_pkg::sfspi_power_e         power_state_out,
  output logic                            selected_out,
  output logic                            held_out,
  output logic                            rx_valid_out,
  input  wire logic                       rx_ready_in,
  output sfspi_pkg::sfspi_rx_byte_s       rx_byte_out,
  output logic                            rx_dropped_out,
  output sfspi_pkg::sfspi_addr_s          addr_out,
  output logic                            addr_valid_out,
  input  wire logic                       tx_enable_in,
  input  wire sfspi_pkg::sfspi_width_e    tx_width_in,
  input  wire logic                       tx_valid_in,
  output logic                            tx_ready_out,
  input  wire logic [sfspi_pkg::BYTE_W-1:0] tx_data_in,
  output logic                            tx_underrun_out
);

  sfspi_pkg::sfspi_pins_s    pins_in;
  sfspi_pkg::sfspi_pins_s    sync1_reg;
  sfspi_pkg::sfspi_pins_s    sync2_reg;
  sfspi_pkg::sfspi_pins_s    prev_reg;
  logic                      frame_reg;
  logic                      held_reg;
  logic                      sck_rise;
  logic                      sck_fall;
  logic                      cs_fall;
  logic                      hold_n_now;
  logic                      hold_n_prev;
  logic                      live;
  logic [2:0]                bit_cnt_reg;
  logic [6:0]                rx_shift_reg;
  logic [8:0]                byte_idx_reg;
  logic                      rx_sample;
  logic                      byte_done;
  logic [7:0]                rx_byte_next;
  sfspi_pkg::sfspi_kind_e    rx_kind;
  sfspi_pkg::sfspi_rx_byte_s fifo_in;
  logic                      fifo_push;
  logic                      fifo_in_ready;
  logic                      dropped_reg;
  logic [23:0]               addr_reg;
  logic                      addr_valid_reg;
  sfspi_pkg::sfspi_width_e   tx_width_reg;
  logic [7:0]                tx_shift_reg;
  logic [3:0]                tx_left_reg;
  logic [3:0]                io_out_reg;
  logic                      tx_mode;
  logic                      tx_load;
  logic [7:0]                tx_src;
  logic                      underrun_reg;
  logic                      wp_n_reg;
  sfspi_pkg::sfspi_power_e   power_reg;

  function automatic logic [3:0] width_step(sfspi_pkg::sfspi_width_e w);
    unique case (w)
      sfspi_pkg::SFSPI_WIDTH_SINGLE: width_step = sfspi_pkg::STEP_SINGLE;
      sfspi_pkg::SFSPI_WIDTH_DUAL:   width_step = sfspi_pkg::STEP_DUAL;
      sfspi_pkg::SFSPI_WIDTH_QUAD:   width_step = sfspi_pkg::STEP_QUAD;
      default:                       width_step = sfspi_pkg::STEP_SINGLE;
    endcase
  endfunction : width_step

  // Top bits of the byte onto the lines, most significant first
  function automatic logic [3:0] pin_bits(logic [7:0] v,
                                          sfspi_pkg::sfspi_width_e w);
    unique case (w)
      sfspi_pkg::SFSPI_WIDTH_DUAL: pin_bits = {2'h0, v[7], v[6]};
      sfspi_pkg::SFSPI_WIDTH_QUAD: pin_bits = v[7:4];
      default:                     pin_bits = {2'h0, v[7], 1'b0};
    endcase
  endfunction : pin_bits

  assign pins_in = '{cs_n: cs_n_in, sck: sck_in, io: io_in};

  // Two-stage synchroniser for every pin, then an edge-detect stage
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1_reg <= sfspi_pkg::PINS_RST;
      sync2_reg <= sfspi_pkg::PINS_RST;
      prev_reg  <= sfspi_pkg::PINS_RST;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Edges of the clock pin, valid for either idle level, and the select fall
  assign sck_rise = sync2_reg.sck & ~prev_reg.sck;
  assign sck_fall = ~sync2_reg.sck & prev_reg.sck;
  assign cs_fall  = ~sync2_reg.cs_n & prev_reg.cs_n;

  assign hold_n_now  = quad_pins_enable_in | sync2_reg.io[3];
  assign hold_n_prev = quad_pins_enable_in | prev_reg.io[3];

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      frame_reg <= 1'b0;
    end else if (sync2_reg.cs_n) begin
      frame_reg <= 1'b0;
    end else if (cs_fall) begin
      frame_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || sync2_reg.cs_n) begin
      held_reg <= 1'b0;
    end else if (frame_reg && !held_reg && !hold_n_now && hold_n_prev &&
                 !sync2_reg.sck) begin
      held_reg <= 1'b1;
    end else if (held_reg && hold_n_now && !hold_n_prev &&
                 !sync2_reg.sck) begin
      held_reg <= 1'b0;
    end
  end

  assign live = frame_reg & ~held_reg;

  // Receive path: one bit per rising edge on line zero
  assign rx_sample    = live & sck_rise & ~io_oe_out[0];
  assign byte_done    = rx_sample && (bit_cnt_reg == sfspi_pkg::BIT_LAST);
  assign rx_byte_next = {rx_shift_reg, sync2_reg.io[0]};

  always_comb begin
    if (byte_idx_reg == sfspi_pkg::IDX_CMD) begin
      rx_kind = sfspi_pkg::SFSPI_KIND_CMD;
    end else if (byte_idx_reg < sfspi_pkg::IDX_DATA0) begin
      rx_kind = sfspi_pkg::SFSPI_KIND_ADDR;
    end else begin
      rx_kind = sfspi_pkg::SFSPI_KIND_DATA;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !frame_reg) begin
      bit_cnt_reg  <= sfspi_pkg::BIT_FIRST;
      rx_shift_reg <= 7'h00;
    end else if (rx_sample) begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= rx_byte_next[6:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !frame_reg) begin
      byte_idx_reg <= sfspi_pkg::IDX_RST;
    end else if (byte_done && byte_idx_reg != sfspi_pkg::IDX_LIMIT) begin
      byte_idx_reg <= byte_idx_reg + 9'h001;
    end
  end

  // Data beyond one page of program data is not passed on
  assign fifo_push = byte_done && (byte_idx_reg < sfspi_pkg::IDX_LIMIT);
  assign fifo_in   = '{kind: rx_kind, data: rx_byte_next};

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dropped_reg <= 1'b0;
    end else if (byte_done && (!fifo_in_ready ||
                 byte_idx_reg >= sfspi_pkg::IDX_LIMIT)) begin
      dropped_reg <= 1'b1;
    end else if (cs_fall) begin
      dropped_reg <= 1'b0;
    end
  end

  sfspi_fifo #(
    .WIDTH (sfspi_pkg::RX_W),
    .DEPTH (sfspi_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_byte_out)
  );

  // Three address bytes: page number high, byte within page low
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !frame_reg) begin
      addr_reg       <= sfspi_pkg::ADDR_RST;
      addr_valid_reg <= 1'b0;
    end else if (byte_done && rx_kind == sfspi_pkg::SFSPI_KIND_ADDR) begin
      addr_reg       <= {addr_reg[15:0], rx_byte_next};
      addr_valid_reg <= (byte_idx_reg == sfspi_pkg::IDX_ADDR_END);
    end
  end

  // Transmit path: lines change only on falling edges
  assign tx_mode      = frame_reg & tx_enable_in;
  assign tx_load      = live & sck_fall & tx_enable_in &
                        (tx_left_reg == sfspi_pkg::BITS_NONE);
  assign tx_ready_out = tx_load;
  assign tx_src       = tx_valid_in ? tx_data_in : sfspi_pkg::BYTE_RST;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !tx_mode) begin
      tx_width_reg <= sfspi_pkg::SFSPI_WIDTH_SINGLE;
      tx_shift_reg <= sfspi_pkg::BYTE_RST;
      tx_left_reg  <= sfspi_pkg::BITS_NONE;
      io_out_reg   <= sfspi_pkg::IO_RST;
    end else if (tx_load) begin
      tx_width_reg <= tx_width_in;
      io_out_reg   <= pin_bits(tx_src, tx_width_in);
      tx_shift_reg <= tx_src << width_step(tx_width_in);
      tx_left_reg  <= sfspi_pkg::BITS_BYTE - width_step(tx_width_in);
    end else if (live && sck_fall) begin
      io_out_reg   <= pin_bits(tx_shift_reg, tx_width_reg);
      tx_shift_reg <= tx_shift_reg << width_step(tx_width_reg);
      tx_left_reg  <= tx_left_reg - width_step(tx_width_reg);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      underrun_reg <= 1'b0;
    end else if (tx_load && !tx_valid_in) begin
      underrun_reg <= 1'b1;
    end else if (cs_fall) begin
      underrun_reg <= 1'b0;
    end
  end

  assign io_out       = io_out_reg;
  assign io_oe_out[1] = tx_mode;
  assign io_oe_out[0] = tx_mode &&
                        tx_width_reg != sfspi_pkg::SFSPI_WIDTH_SINGLE;
  assign io_oe_out[2] = tx_mode && quad_pins_enable_in &&
                        tx_width_reg == sfspi_pkg::SFSPI_WIDTH_QUAD;
  assign io_oe_out[3] = io_oe_out[2];

  // Protect level only counts while the line is not a data line
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wp_n_reg <= 1'b1;
    end else begin
      wp_n_reg <= quad_pins_enable_in | sync2_reg.io[2];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      power_reg <= sfspi_pkg::SFSPI_PWR_STANDBY;
    end else if (frame_reg) begin
      power_reg <= sfspi_pkg::SFSPI_PWR_ACTIVE;
    end else if (busy_in) begin
      power_reg <= sfspi_pkg::SFSPI_PWR_BUSY;
    end else begin
      power_reg <= sfspi_pkg::SFSPI_PWR_STANDBY;
    end
  end

  assign wp_n_out        = wp_n_reg;
  assign power_state_out = power_reg;
  assign selected_out    = frame_reg;
  assign held_out        = held_reg;
  assign rx_dropped_out  = dropped_reg;
  assign addr_out        = addr_reg;
  assign addr_valid_out  = addr_valid_reg;
  assign tx_underrun_out = underrun_reg;

endmodule : sfspi_front_end
`default_nettype wire

/* logic/sfspi_pkg.sv */
`default_nettype none
package sfspi_pkg;

  localparam int          BYTE_W       = 8;
  localparam int          IO_W         = 4;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          PAGE_BYTES   = 256;
  localparam int          PAGE_COUNT   = 65536;
  localparam int          PAGE_W       = 16;
  localparam int          ADDR_BYTES   = 3;

  // Byte position within a frame: instruction, three address bytes, data
  localparam logic [8:0]  IDX_CMD      = 9'h000;
  localparam logic [8:0]  IDX_ADDR_END = 9'h003;
  localparam logic [8:0]  IDX_DATA0    = 9'h004;
  localparam logic [8:0]  IDX_LIMIT    = 9'h104;
  localparam logic [8:0]  IDX_RST      = 9'h000;

  localparam logic [2:0]  BIT_FIRST    = 3'h0;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  BITS_NONE    = 4'h0;
  localparam logic [3:0]  BITS_BYTE    = 4'h8;
  localparam logic [3:0]  STEP_SINGLE  = 4'h1;
  localparam logic [3:0]  STEP_DUAL    = 4'h2;
  localparam logic [3:0]  STEP_QUAD    = 4'h4;

  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [3:0]  IO_RST       = 4'h0;
  localparam logic [23:0] ADDR_RST     = 24'h000000;

  typedef enum logic [1:0] {
    SFSPI_WIDTH_SINGLE,
    SFSPI_WIDTH_DUAL,
    SFSPI_WIDTH_QUAD
  } sfspi_width_e;

  typedef enum logic [1:0] {
    SFSPI_KIND_CMD,
    SFSPI_KIND_ADDR,
    SFSPI_KIND_DATA
  } sfspi_kind_e;

  typedef enum logic [1:0] {
    SFSPI_PWR_STANDBY,
    SFSPI_PWR_BUSY,
    SFSPI_PWR_ACTIVE
  } sfspi_power_e;

  typedef struct packed {
    sfspi_kind_e       kind;
    logic [BYTE_W-1:0] data;
  } sfspi_rx_byte_s;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [BYTE_W-1:0] offset;
  } sfspi_addr_s;

  typedef struct packed {
    logic            cs_n;
    logic            sck;
    logic [IO_W-1:0] io;
  } sfspi_pins_s;

  // Chip select settles low in reset so a select held through reset
  // produces no falling edge; hold and protect settle at their idle high
  localparam sfspi_pins_s PINS_RST = '{cs_n: 1'b0, sck: 1'b0, io: 4'hc};

  localparam int RX_W = $bits(sfspi_rx_byte_s);

endpackage : sfspi_pkg
`default_nettype wire
